// ### topc_pkg.sv
package topc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] TOPC_ADDR_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] TOPC_ADDR_MODULO         = 4'h1;
    localparam logic [3:0] TOPC_ADDR_COUNT          = 4'h2;
    localparam logic [3:0] TOPC_ADDR_IRQ_STATUS     = 4'h3;
    localparam logic [3:0] TOPC_ADDR_IRQ_ENABLE     = 4'h4;
    localparam logic [3:0] TOPC_ADDR_IRQ_CLEAR      = 4'h5;

    // ------------------------------------------------------------
    // Status/control fields
    // ------------------------------------------------------------
    localparam int TOPC_BIT_OVF      = 7;
    localparam int TOPC_BIT_OVF_IE   = 6;
    localparam int TOPC_BIT_CENTER   = 5;
    localparam int TOPC_CLKSRC_HI    = 4;
    localparam int TOPC_CLKSRC_LO    = 3;
    localparam int TOPC_PRESCALE_HI  = 2;
    localparam int TOPC_PRESCALE_LO  = 0;
    localparam logic [7:0] TOPC_STATUS_CONTROL_RST = 8'h00;
    localparam logic [7:0] TOPC_CTRL_WR_MASK       = 8'h7f;

    // ------------------------------------------------------------
    // Clock sources
    // ------------------------------------------------------------
    localparam logic [1:0] TOPC_SRC_OFF   = 2'h0;
    localparam logic [1:0] TOPC_SRC_BUS   = 2'h1;
    localparam logic [1:0] TOPC_SRC_FIXED = 2'h2;
    localparam logic [1:0] TOPC_SRC_EXT   = 2'h3;

    // ------------------------------------------------------------
    // Interrupt status bits
    // ------------------------------------------------------------
    localparam int TOPC_IRQ_BIT_OVF   = 0;
    localparam int TOPC_IRQ_BIT_STICK = 1;
    localparam logic [1:0] TOPC_IRQ_RST = 2'h0;

    localparam logic [15:0] TOPC_MODULO_RST = 16'hffff;
    localparam logic [15:0] TOPC_COUNT_RST  = 16'h0000;

endpackage

// ### topc_timer.sv
// Functional notes
// - Up-count: flag sets when counter wraps to zero after hitting modulo.
// - Center mode: flag sets at modulo, as counter steps down.
// - Flag clears only after read-while-set then write of zero.
// - New overflow during clear sequence restarts it; flag stays set.
// - Writing one to the flag does nothing; reset clears it.
// - Interrupt request while flag and overflow interrupt enable both set.
// - Center select clear (reset): counter counts up only.
// - Center select set: counter counts up and down, all channels center PWM.
// - Bits 4:3 disable the timer or pick one of three sources.
// - External and fixed clocks synchronised to bus clock first.
// - Bits 2:0 pick one of eight prescale ratios.
// - Prescaler divides whichever source is selected after synchronisation.
// - All settings are shared by every channel.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
module topc_timer
    import topc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    // Register port
    input  wire logic [3:0]       addr_i,
    input  wire logic [15:0]      wdata_i,
    input  wire logic             wr_i,
    input  wire logic             rd_i,
    output logic      [15:0]      rdata_o,
    // Clock inputs from pins
    input  wire logic             ext_clk_i,
    input  wire logic             fixed_system_clock_i,
    // Shared channel controls
    output logic                  center_aligned_pwm_o,
    output logic                  count_tick_o,
    output logic      [CNT_W-1:0] count_o,
    // Interrupt
    output logic                  irq_o
);
    import topc_pkg::*;

    // Only the 16-bit counter path is built
    if (CNT_W != 16) begin : g_cnt_w_check
        $error("topc_timer supports only CNT_W of 16");
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic [6:0]  ctrl_q;
    logic        ovf_q;
    logic        armed_q;
    logic [15:0] modulo_q;
    logic [15:0] count_q;
    logic        down_q;
    logic        tick_q;
    logic        ovf_ev;

    wire logic wr_sc = wr_i && (addr_i == TOPC_ADDR_STATUS_CONTROL);
    wire logic rd_sc = rd_i && (addr_i == TOPC_ADDR_STATUS_CONTROL);
    wire logic [1:0] clk_src = ctrl_q[TOPC_CLKSRC_HI:TOPC_CLKSRC_LO];
    wire logic [2:0] prescale = ctrl_q[TOPC_PRESCALE_HI:TOPC_PRESCALE_LO];
    wire logic center = ctrl_q[TOPC_BIT_CENTER];

    // Shared by every channel; one copy only
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_q <= TOPC_STATUS_CONTROL_RST[6:0];
        end else if (wr_sc) begin
            ctrl_q <= wdata_i[6:0] & TOPC_CTRL_WR_MASK[6:0];
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            modulo_q <= TOPC_MODULO_RST;
        end else if (wr_i && addr_i == TOPC_ADDR_MODULO) begin
            modulo_q <= wdata_i;
        end
    end

    // ------------------------------------------------------------
    // Overflow flag and clear sequence
    // ------------------------------------------------------------
    // A new overflow wins over the clear and disarms the sequence
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ovf_q   <= 1'b0;
            armed_q <= 1'b0;
        end else if (ovf_ev) begin
            ovf_q   <= 1'b1;
            armed_q <= 1'b0;
        end else if (wr_sc && armed_q && !wdata_i[TOPC_BIT_OVF]) begin
            ovf_q   <= 1'b0;
            armed_q <= 1'b0;
        end else if (rd_sc && ovf_q) begin
            armed_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Source synchronisers and edge detect
    // ------------------------------------------------------------
    logic [2:0] ext_sync_q;
    logic [2:0] fix_sync_q;

    // Second and third stages feed edge detect so the first stage stays private
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ext_sync_q <= 3'h0;
            fix_sync_q <= 3'h0;
        end else begin
            ext_sync_q <= {ext_sync_q[1:0], ext_clk_i};
            fix_sync_q <= {fix_sync_q[1:0], fixed_system_clock_i};
        end
    end

    logic src_edge;
    always_comb begin
        case (clk_src)
            TOPC_SRC_OFF:   src_edge = 1'b0;
            TOPC_SRC_BUS:   src_edge = 1'b1;
            TOPC_SRC_FIXED: src_edge = fix_sync_q[1] & ~fix_sync_q[2];
            TOPC_SRC_EXT:   src_edge = ext_sync_q[1] & ~ext_sync_q[2];
            default:        src_edge = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Prescaler after selection
    // ------------------------------------------------------------
    logic [6:0] pre_q;
    wire logic [6:0] pre_mask = 7'((8'h01 << prescale) - 8'h01);
    wire logic tick_d = src_edge && ((pre_q & pre_mask) == pre_mask);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pre_q <= 7'h00;
        end else if (src_edge) begin
            pre_q <= pre_q + 7'h01;
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_comb begin
        ovf_ev = 1'b0;
        if (tick_d) begin
            if (!center) begin
                ovf_ev = (count_q == modulo_q);
            end else begin
                ovf_ev = !down_q && (count_q >= modulo_q) && (modulo_q != 16'h0000);
            end
        end
    end

    // Counter holds when no tick arrives and the count is not written, including source off
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_q <= TOPC_COUNT_RST;
            down_q  <= 1'b0;
        end else if (wr_i && addr_i == TOPC_ADDR_COUNT) begin
            count_q <= TOPC_COUNT_RST;
            down_q  <= 1'b0;
        end else if (tick_d) begin
            if (!center) begin
                down_q  <= 1'b0;
                count_q <= (count_q == modulo_q) ? 16'h0000 : count_q + 16'h0001;
            end else if (!down_q) begin
                if (count_q >= modulo_q && modulo_q != 16'h0000) begin
                    down_q  <= 1'b1;
                    count_q <= count_q - 16'h0001;
                end else begin
                    count_q <= count_q + 16'h0001;
                end
            end else begin
                if (count_q <= 16'h0001) begin
                    down_q <= 1'b0;
                end
                count_q <= (count_q == 16'h0000) ? 16'h0000 : count_q - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= tick_d;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, enable, clear
    // ------------------------------------------------------------
    logic [1:0] irq_st_q;
    logic [1:0] irq_en_q;
    wire logic clr_wr = wr_i && addr_i == TOPC_ADDR_IRQ_CLEAR;

    // Set wins over clear so no event is lost
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_st_q <= TOPC_IRQ_RST;
        end else begin
            irq_st_q[TOPC_IRQ_BIT_OVF] <= ovf_q || (irq_st_q[TOPC_IRQ_BIT_OVF] &&
                !(clr_wr && wdata_i[TOPC_IRQ_BIT_OVF]));
            irq_st_q[TOPC_IRQ_BIT_STICK] <= ovf_ev || (irq_st_q[TOPC_IRQ_BIT_STICK] &&
                !(clr_wr && wdata_i[TOPC_IRQ_BIT_STICK]));
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_en_q <= TOPC_IRQ_RST;
        end else if (wr_i && addr_i == TOPC_ADDR_IRQ_ENABLE) begin
            irq_en_q <= wdata_i[1:0];
        end
    end

    // Ovf source follows the flag itself, gated by its own enable bit
    wire logic irq_d = (ovf_q && ctrl_q[TOPC_BIT_OVF_IE]) ||
                       (irq_st_q[TOPC_IRQ_BIT_STICK] && irq_en_q[TOPC_IRQ_BIT_STICK]);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // Read data and outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            case (addr_i)
                TOPC_ADDR_STATUS_CONTROL: rdata_o <= {8'h00, ovf_q, ctrl_q};
                TOPC_ADDR_MODULO:         rdata_o <= modulo_q;
                TOPC_ADDR_COUNT:          rdata_o <= count_q;
                TOPC_ADDR_IRQ_STATUS:     rdata_o <= {14'h0000, irq_st_q};
                TOPC_ADDR_IRQ_ENABLE:     rdata_o <= {14'h0000, irq_en_q};
                default:                  rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            center_aligned_pwm_o <= 1'b0;
        end else begin
            center_aligned_pwm_o <= center;
        end
    end

    assign count_o      = count_q;
    assign count_tick_o = tick_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    wire logic cnt_wr = wr_i && (addr_i == TOPC_ADDR_COUNT);

    AST_IRQ_FOLLOWS_FLAG: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (ovf_q && ctrl_q[TOPC_BIT_OVF_IE]) |=> irq_o)
        else $error("irq missing while flag and enable set");
    AST_ONE_WRITE_KEEPS: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (ovf_q && wr_sc && wdata_i[TOPC_BIT_OVF]) |=> ovf_q)
        else $error("writing one cleared the flag");
    AST_CLEAR_NEEDS_READ: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (ovf_q && !armed_q && !ovf_ev) |=> ovf_q)
        else $error("flag cleared without prior read");
    AST_OVF_SETS: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ovf_ev |=> ovf_q)
        else $error("overflow did not set flag");
    AST_RESTART: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ovf_ev |=> !armed_q)
        else $error("sequence not restarted");
    AST_SRC_OFF_HOLD: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (clk_src == TOPC_SRC_OFF && !(wr_i && addr_i == TOPC_ADDR_COUNT))
        |=> $stable(count_q))
        else $error("counter moved with source off");
    AST_UP_WRAP: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (tick_d && !center && count_q == modulo_q && !wr_i) |=> count_q == 16'h0000)
        else $error("up counter did not wrap");
    AST_CENTER_TURN: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (ovf_ev && center && !cnt_wr) |=> down_q)
        else $error("center overflow without turn down");
    AST_DIV1: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (clk_src == TOPC_SRC_BUS && prescale == 3'h0) |-> tick_d)
        else $error("divide by one missed a tick");
    AST_CLEAR_DONE: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (wr_sc && armed_q && !wdata_i[TOPC_BIT_OVF] && !ovf_ev) |=> !ovf_q)
        else $error("clear sequence left the flag set");
    AST_ARM_ON_READ: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (rd_sc && !wr_i && ovf_q && !ovf_ev) |=> armed_q)
        else $error("read with flag set did not arm the clear");
    AST_NO_SPURIOUS_SET: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (!ovf_q && !ovf_ev) |=> !ovf_q)
        else $error("flag set without an overflow");
    AST_UP_STEP: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (tick_d && !center && count_q != modulo_q && !cnt_wr)
        |=> (count_q == $past(count_q) + 16'h0001))
        else $error("up counter did not step by one");
    AST_UP_DIRECTION: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (tick_d && !center) |=> !down_q)
        else $error("up mode counted down");
    AST_CENTER_UP_STEP: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (tick_d && center && !down_q && count_q < modulo_q && !cnt_wr)
        |=> (count_q == $past(count_q) + 16'h0001))
        else $error("center mode did not step up");
    AST_CENTER_DOWN_STEP: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (tick_d && center && down_q && count_q != 16'h0000 && !cnt_wr)
        |=> (count_q == $past(count_q) - 16'h0001))
        else $error("center mode did not step down");
    AST_CENTER_BOTTOM: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (tick_d && center && down_q && count_q <= 16'h0001 && !cnt_wr) |=> !down_q)
        else $error("center mode did not turn up at bottom");
    AST_NO_TICK_HOLD: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (!tick_d && !cnt_wr) |=> $stable(count_q))
        else $error("counter moved without a tick");
    AST_SRC_OFF_NO_TICK: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (clk_src == TOPC_SRC_OFF) |-> !tick_d)
        else $error("tick with source off");
    AST_DIV2_SPACING: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (tick_d && clk_src == TOPC_SRC_BUS && prescale == 3'h1 && !wr_sc) |=> !tick_d)
        else $error("divide by two ticked twice in a row");
    AST_EXT_ONE_TICK: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (tick_d && clk_src == TOPC_SRC_EXT && !wr_sc) |=> !tick_d)
        else $error("external edge gave two ticks");
    AST_FIX_ONE_TICK: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (tick_d && clk_src == TOPC_SRC_FIXED && !wr_sc) |=> !tick_d)
        else $error("fixed clock edge gave two ticks");
    AST_IRQ_QUIET: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (!(ovf_q && ctrl_q[TOPC_BIT_OVF_IE]) &&
         !(irq_st_q[TOPC_IRQ_BIT_STICK] && irq_en_q[TOPC_IRQ_BIT_STICK])) |=> !irq_o)
        else $error("irq without an enabled source");
    AST_CENTER_ALIGNED_PWM_FOLLOWS: assert property (@(posedge clk_i) disable iff (!resetn_i)
        1'b1 |=> (center_aligned_pwm_o == $past(center)))
        else $error("center output does not follow select");

endmodule

// ### topc_timer_tb.sv
module topc_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import topc_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk, resetn, wr, rd, ext_clk, fixed_clk, center, tick, irq;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata, count, mod_val, prev_cnt, rv;
    logic        mon_en, mon_center;
    int          n_errors, tests_run, cyc, ticks;

    topc_timer #(.CNT_W(16)) dut (
        .clk_i                (clk),
        .resetn_i             (resetn),
        .addr_i               (addr),
        .wdata_i              (wdata),
        .wr_i                 (wr),
        .rd_i                 (rd),
        .rdata_o              (rdata),
        .ext_clk_i            (ext_clk),
        .fixed_system_clock_i (fixed_clk),
        .center_aligned_pwm_o (center),
        .count_tick_o         (tick),
        .count_o              (count),
        .irq_o                (irq)
    );

    always #2 clk = ~clk;

    // ------------------------------------------------------------
    // Slow sources, tick counter, watchdog, wrap monitor
    // ------------------------------------------------------------
    // Slow clocks are derived from the bus clock, so edge counts stay exact
    always @(posedge clk) begin
        cyc       <= cyc + 1;
        fixed_clk <= cyc[3];
        ext_clk   <= cyc[4];
        prev_cnt  <= count;
        if (tick === 1'b1) ticks <= ticks + 1;
        // Gated by the tick so a software reload of the count is not taken for a step
        if (mon_en && tick === 1'b1) begin
            if (prev_cnt === mod_val)
                chk("count after mod", mon_center ? mod_val - 16'h1 : 16'h0, count);
            chk("count within modulo", 16'h1, {15'h0, count <= mod_val});
        end
        if (cyc > 20000) begin
            n_errors = n_errors + 1;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(what, exp, rdata);
    endtask

    // Tolerance of one tick covers prescaler phase at the window edges
    task automatic measure(input logic [15:0] ctrl, input int exp);
        wr_reg(TOPC_ADDR_STATUS_CONTROL, ctrl);
        #1 ticks = 0;
        repeat (256) @(posedge clk);
        #1 chk("tick count", 16'h1, {15'h0, ticks >= exp - 1 && ticks <= exp + 1});
    endtask

    task automatic end_sim();
        $display("Checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 0; resetn = 0; addr = 0; wdata = 0; wr = 0; rd = 0;
        ext_clk = 0; fixed_clk = 0; cyc = 0; ticks = 0; mon_en = 0; mon_center = 0;
        mod_val = 16'hffff; prev_cnt = 0; n_errors = 0; tests_run = 0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        rd_chk(TOPC_ADDR_STATUS_CONTROL, 16'h0000, "status_control reset");
        chk("irq reset", 16'h0, {15'h0, irq});
        chk("center reset", 16'h0, {15'h0, center});
        rd_chk(TOPC_ADDR_MODULO, 16'hffff, "modulo reset");
        rd_chk(4'hf, 16'h0000, "unmapped read");
        wr_reg(TOPC_ADDR_STATUS_CONTROL, 16'h0080);
        rd_chk(TOPC_ADDR_STATUS_CONTROL, 16'h0000, "flag write one");
        $display("Test reset done");

        wr_reg(TOPC_ADDR_MODULO, 16'h0003);
        mod_val = 16'h0003;
        mon_en  = 1'b1;
        wr_reg(TOPC_ADDR_STATUS_CONTROL, 16'h0008);
        repeat (20) @(posedge clk);
        rd_chk(TOPC_ADDR_STATUS_CONTROL, 16'h0088, "flag up count");
        wr_reg(TOPC_ADDR_STATUS_CONTROL, 16'h00c0);
        rd_chk(TOPC_ADDR_STATUS_CONTROL, 16'h00c0, "flag kept on one");
        chk("irq flag enabled", 16'h1, {15'h0, irq});
        rv = count;
        repeat (10) @(posedge clk);
        #1 chk("count held", rv, count);
        wr_reg(TOPC_ADDR_STATUS_CONTROL, 16'h0040);
        rd_chk(TOPC_ADDR_STATUS_CONTROL, 16'h0040, "flag cleared");
        repeat (2) @(posedge clk);
        #1 chk("irq after clear", 16'h0, {15'h0, irq});
        $display("Test overflow flag done");

        wr_reg(TOPC_ADDR_STATUS_CONTROL, 16'h0008);
        repeat (20) @(posedge clk);
        rd_chk(TOPC_ADDR_STATUS_CONTROL, 16'h0088, "flag before restart");
        repeat (8) @(posedge clk);
        wr_reg(TOPC_ADDR_STATUS_CONTROL, 16'h0000);
        rd_chk(TOPC_ADDR_STATUS_CONTROL, 16'h0080, "flag after restart");
        wr_reg(TOPC_ADDR_STATUS_CONTROL, 16'h0000);
        rd_chk(TOPC_ADDR_STATUS_CONTROL, 16'h0000, "flag second clear");
        $display("Test clear restart done");

        wr_reg(TOPC_ADDR_IRQ_ENABLE, 16'h0002);
        rd_chk(TOPC_ADDR_IRQ_ENABLE, 16'h0002, "irq enable readback");
        wr_reg(TOPC_ADDR_STATUS_CONTROL, 16'h0008);
        repeat (20) @(posedge clk);
        wr_reg(TOPC_ADDR_STATUS_CONTROL, 16'h0080);
        rd_chk(TOPC_ADDR_IRQ_STATUS, 16'h0003, "irq status set");
        chk("irq sticky", 16'h1, {15'h0, irq});
        wr_reg(TOPC_ADDR_IRQ_STATUS, 16'h0000);
        wr_reg(TOPC_ADDR_IRQ_CLEAR, 16'h0002);
        rd_chk(TOPC_ADDR_IRQ_STATUS, 16'h0001, "irq status cleared");
        repeat (2) @(posedge clk);
        #1 chk("irq sticky cleared", 16'h0, {15'h0, irq});
        wr_reg(TOPC_ADDR_STATUS_CONTROL, 16'h0000);
        rd_chk(TOPC_ADDR_STATUS_CONTROL, 16'h0080, "flag needs read");
        rd_chk(TOPC_ADDR_STATUS_CONTROL, 16'h0080, "flag arm");
        wr_reg(TOPC_ADDR_STATUS_CONTROL, 16'h0000);
        $display("Test interrupt status done");

        wr_reg(TOPC_ADDR_COUNT, 16'h0000);
        mon_center = 1'b1;
        wr_reg(TOPC_ADDR_STATUS_CONTROL, 16'h0028);
        @(posedge clk);
        #1 chk("center select", 16'h1, {15'h0, center});
        repeat (30) @(posedge clk);
        rd_chk(TOPC_ADDR_STATUS_CONTROL, 16'h00a8, "flag center");
        wr_reg(TOPC_ADDR_STATUS_CONTROL, 16'h0000);
        mon_en = 1'b0;
        @(posedge clk);
        #1 chk("center off", 16'h0, {15'h0, center});
        $display("Test center mode done");

        wr_reg(TOPC_ADDR_STATUS_CONTROL, 16'h0048);
        repeat (20) @(posedge clk);
        #1 chk("irq before reset", 16'h1, {15'h0, irq});
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd_chk(TOPC_ADDR_STATUS_CONTROL, 16'h0000, "flag after reset");
        chk("irq after reset", 16'h0, {15'h0, irq});
        rd_chk(TOPC_ADDR_MODULO, 16'hffff, "modulo after reset");
        $display("Test mid-run reset done");

        wr_reg(TOPC_ADDR_MODULO, 16'hffff);
        for (int n = 0; n < 8; n++) begin
            measure(16'h0008 | 16'(n), 256 >> n);
        end
        measure(16'h0011, 8);
        measure(16'h0018, 8);
        measure(16'h0019, 4);
        measure(16'h0000, 0);
        $display("Test clock sources done");
        end_sim();
    end
endmodule
